// ### design/fsp_ctrl.sv
// Purpose: Flash self-programming controller: page buffer, erase, write, locks
// Assumes: CPU gives store and load strobes with pointer and data pair
// Notes:   Flash array is outside; this block drives its erase/write/lock ports
//
// Function
// RULE1 - Software erases page before writing it
// RULE2 - Buffer words load in any order
// RULE3 - Same page for erase and write
// RULE4 - Pattern X0000011 plus store erases page
// RULE5 - Erase: other region readable, own halts
// RULE6 - Pattern 00000001 plus store loads word
// RULE7 - Buffer clears after write, reenable, reset
// RULE8 - Load each buffer word only once
// RULE9 - EEPROM write during loading discards buffer
// RULE10 - Pattern X0000101 plus store writes page
// RULE11 - Write: other region readable, own halts
// RULE12 - Ready interrupt held while enable clear
// RULE13 - Block region reads, busy flag during ops
// RULE14 - Software reenables region, moves vectors
// RULE15 - Lock bits programmed where data zero
// RULE16 - Lock data bits 7,6 set recommended
// RULE17 - EEPROM write refuses programming and readback
// RULE18 - Pointer one returns lock bits
// RULE19 - Lock-set and enable auto-clear on timeout
// RULE20 - Pointers zero, three, two return fuses
// RULE21 - Programmed bits read zero, unprogrammed one
// RULE22 - Signature table layout with calibration byte
// RULE23 - Enable arms store four cycles, clears
// RULE24 - Only five legal low-bit patterns act
//
// Added by the designer: the register addresses and the plain strobed port.
`timescale 1ns/1ns
`include "fsp_defines.svh"
module fsp_ctrl
    import fsp_pkg::*;
#(
    parameter int PAGE_WORDS   = 128,
    parameter int WORD_BITS    = 7,
    parameter int PAGE_BITS    = 8,
    parameter int NO_READ_WHILE_WRITE_REGION_FIRST   = 224,
    parameter int OP_CYCLES    = `FSP_OP_CYCLES,
    parameter logic [7:0] SIG_BYTE0 = 8'h5A, // Arbitrary signature values
    parameter logic [7:0] SIG_BYTE1 = 8'hA5,
    parameter logic [7:0] SIG_BYTE2 = 8'h3C,
    parameter logic [7:0] CAL_BYTE  = 8'h80,
    parameter logic [71:0] SERIAL   = 72'h0
) (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        sys_rst_in,
    // Control register port
    input  wire logic        ctrl_wr_in,
    input  wire logic [7:0]  ctrl_wdata_in,
    input  wire logic        ctrl_rd_in,
    output logic      [7:0]  ctrl_rdata_out,
    // CPU instruction strobes
    input  wire logic        store_in,
    input  wire logic        load_in,
    input  wire logic [15:0] pointer_in,
    input  wire logic [15:0] data_pair_in,
    output logic      [7:0]  load_data_out,
    output logic             load_special_out,
    // EEPROM status
    input  wire logic        eeprom_write_busy_in,
    // Fuse and lock cells, one means unprogrammed
    input  wire logic [7:0]  fuse_low_byte_in,
    input  wire logic [7:0]  fuse_high_byte_in,
    input  wire logic [2:0]  fuse_extended_byte_in,
    input  wire logic [5:0]  lock_bits_in,
    // Flash array control
    output logic             flash_erase_out,
    output logic             flash_write_out,
    output logic             lock_prog_out,
    output logic [5:0]       lock_data_out,
    output logic [PAGE_BITS-1:0] flash_page_out,
    output logic [15:0]      flash_wdata_out,
    output logic             rww_block_out,
    output logic             cpu_halt_out,
    output logic             ready_irq_out
);
    localparam int CW = $clog2(OP_CYCLES + 1);

    fsp_state_t          state;
    logic [7:0]          ctrl;
    logic [2:0]          store_cnt;
    logic [2:0]          load_cnt;
    logic [CW-1:0]       op_cnt;
    logic                op_write;
    logic                op_no_read_while_write_region;
    logic                region_busy_flag;
    logic                loading;
    logic                buf_clear;
    logic                buf_wr;
    logic [WORD_BITS-1:0] rd_idx;
    logic [15:0]         buf_rdata;
    logic [4:0]          cmd_low;
    logic                cmd_legal;
    logic                store_hit;
    logic                load_hit;
    logic                window_out;
    logic                op_done;
    logic                eep_sync1;
    logic                eep_busy;
    logic [24:0]         cell_sync1;
    logic [24:0]         cell_sync2;
    logic [7:0]          next_load_data;
    logic [PAGE_BITS-1:0] ptr_page;

    // Command decode
    assign cmd_low   = ctrl_wdata_in[4:0];
    assign cmd_legal = cmd_low == `FSP_CMD_LOAD || cmd_low == `FSP_CMD_ERASE
                    || cmd_low == `FSP_CMD_WRITE || cmd_low == `FSP_CMD_LOCK
                    || cmd_low == `FSP_CMD_REEN; // RULE24
    assign store_hit  = state == FSP_ARMED && store_in && !ctrl[`FSP_BIT_SIGNATURE_READ_BIT]
                     && !eep_busy; // RULE17
    assign load_hit   = state == FSP_ARMED && load_in && load_cnt != 3'h0
                     && (ctrl[`FSP_BIT_LOCKSET] || ctrl[`FSP_BIT_SIGNATURE_READ_BIT]); // RULE18 RULE22
    assign window_out = state == FSP_ARMED && store_cnt == 3'h1 && !store_in;
    assign op_done    = state == FSP_BUSY && op_cnt == CW'(1);
    assign ptr_page   = pointer_in[WORD_BITS+PAGE_BITS:WORD_BITS+1];
    assign buf_wr     = store_hit && ctrl[4:1] == 4'h0; // RULE6
    assign buf_clear  = (op_done && op_write)
                     || (store_hit && ctrl[`FSP_BIT_REENABLE])
                     || (loading && eep_busy); // RULE7 RULE9

    // EEPROM busy synchroniser
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            eep_sync1 <= 1'b0;
            eep_busy  <= 1'b0;
        end else begin
            eep_sync1 <= eeprom_write_busy_in;
            eep_busy  <= eep_sync1;
        end
    end

    // Fuse and lock cell synchroniser
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cell_sync1 <= '1;
            cell_sync2 <= '1;
        end else begin
            cell_sync1 <= {fuse_low_byte_in, fuse_high_byte_in, fuse_extended_byte_in,
                           lock_bits_in};
            cell_sync2 <= cell_sync1;
        end
    end

    // Sequencer
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state     <= FSP_IDLE;
            store_cnt <= 3'h0;
            load_cnt  <= 3'h0;
            op_cnt    <= '0;
            op_write  <= 1'b0;
            op_no_read_while_write_region   <= 1'b0;
        end else begin
            unique case (state)
                FSP_IDLE: begin
                    if (ctrl_wr_in && ctrl_wdata_in[`FSP_BIT_EN] && cmd_legal
                        && !eep_busy) begin // RULE17 RULE24
                        state     <= FSP_ARMED;
                        store_cnt <= `FSP_STORE_WINDOW; // RULE23
                        load_cnt  <= `FSP_LOAD_WINDOW;
                    end
                end
                FSP_ARMED: begin
                    store_cnt <= store_cnt - 3'h1;
                    if (load_cnt != 3'h0) begin
                        load_cnt <= load_cnt - 3'h1;
                    end
                    if (store_hit && (ctrl[`FSP_BIT_ERASE] || ctrl[`FSP_BIT_WRITE]
                        || ctrl[`FSP_BIT_LOCKSET])) begin // RULE4 RULE10 RULE15
                        state    <= FSP_BUSY;
                        op_cnt   <= CW'(OP_CYCLES);
                        op_write <= ctrl[`FSP_BIT_WRITE];
                        op_no_read_while_write_region  <= !ctrl[`FSP_BIT_LOCKSET]
                                 && ptr_page >= PAGE_BITS'(NO_READ_WHILE_WRITE_REGION_FIRST);
                    end else if (store_hit || load_hit || window_out) begin
                        state <= FSP_IDLE; // RULE19 RULE23
                    end else if (ctrl[`FSP_BIT_SIGNATURE_READ_BIT] && load_cnt == 3'h1) begin
                        state <= FSP_IDLE;
                    end
                end
                FSP_BUSY: begin
                    op_cnt <= op_cnt - CW'(1);
                    if (op_done) begin
                        state <= FSP_IDLE;
                    end
                end
                default: state <= FSP_IDLE;
            endcase
        end
    end

    // Control register bits
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ctrl <= `FSP_CTRL_RESET;
        end else if (state == FSP_IDLE && ctrl_wr_in) begin
            ctrl[`FSP_BIT_IRQEN] <= ctrl_wdata_in[`FSP_BIT_IRQEN];
            if (ctrl_wdata_in[`FSP_BIT_EN] && cmd_legal && !eep_busy) begin
                ctrl[5:0] <= ctrl_wdata_in[5:0];
            end
        end else if ((state == FSP_ARMED && (store_hit || load_hit || window_out
                     || (ctrl[`FSP_BIT_SIGNATURE_READ_BIT] && load_cnt == 3'h1))
                     && !(store_hit && ctrl[3:1] != 3'h0)) || op_done) begin
            ctrl[5:0] <= 6'h00; // RULE19 RULE23
        end
    end

    // Region busy flag
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            region_busy_flag <= 1'b0;
        end else if (store_hit && (ctrl[`FSP_BIT_ERASE] || ctrl[`FSP_BIT_WRITE])) begin
            region_busy_flag <= 1'b1; // RULE13
        end else if (store_hit && (ctrl[`FSP_BIT_REENABLE] || ctrl[4:1] == 4'h0)) begin
            region_busy_flag <= 1'b0;
        end
    end

    // Loading in progress tracker
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || buf_clear) begin
            loading <= 1'b0;
        end else if (buf_wr) begin
            loading <= 1'b1; // RULE9
        end
    end

    // Flash array control outputs
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flash_erase_out <= 1'b0;
            flash_write_out <= 1'b0;
            lock_prog_out   <= 1'b0;
            lock_data_out   <= 6'h3F;
            flash_page_out  <= '0;
        end else begin
            if (store_hit && (ctrl[`FSP_BIT_ERASE] || ctrl[`FSP_BIT_WRITE])) begin
                flash_page_out <= ptr_page; // RULE4 RULE10
            end
            if (store_hit && ctrl[`FSP_BIT_LOCKSET]) begin
                lock_data_out <= data_pair_in[5:0]; // RULE15
            end
            flash_erase_out <= store_hit && ctrl[`FSP_BIT_ERASE] ? 1'b1 :
                               op_done ? 1'b0 : flash_erase_out;
            flash_write_out <= store_hit && ctrl[`FSP_BIT_WRITE] ? 1'b1 :
                               op_done ? 1'b0 : flash_write_out;
            lock_prog_out   <= store_hit && ctrl[`FSP_BIT_LOCKSET] ? 1'b1 :
                               op_done ? 1'b0 : lock_prog_out;
        end
    end

    // Buffer word streamed to array during page write
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rd_idx <= '0;
        end else if (state == FSP_BUSY && op_write) begin
            rd_idx <= rd_idx + WORD_BITS'(1);
        end else begin
            rd_idx <= '0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            flash_wdata_out <= 16'hFFFF;
        end else begin
            flash_wdata_out <= buf_rdata;
        end
    end

    // Region blocking, halting and ready interrupt
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rww_block_out <= 1'b0;
            cpu_halt_out  <= 1'b0;
            ready_irq_out <= 1'b0;
        end else begin
            rww_block_out <= region_busy_flag; // RULE13
            cpu_halt_out  <= state == FSP_BUSY && op_no_read_while_write_region && !op_done; // RULE5 RULE11
            ready_irq_out <= ctrl[`FSP_BIT_IRQEN] && !ctrl[`FSP_BIT_EN]; // RULE12
        end
    end

    // Fuse, lock and signature readback
    always_comb begin
        next_load_data = 8'hFF;
        if (ctrl[`FSP_BIT_LOCKSET]) begin
            unique case (pointer_in)
                `FSP_ADDR_FUSE_LO:  next_load_data = cell_sync2[24:17]; // RULE20 RULE21
                `FSP_ADDR_LOCK:     next_load_data = {2'b11, cell_sync2[5:0]}; // RULE18
                `FSP_ADDR_FUSE_EXT: next_load_data = {5'h1F, cell_sync2[8:6]};
                `FSP_ADDR_FUSE_HI:  next_load_data = cell_sync2[16:9];
                default:            next_load_data = 8'hFF;
            endcase
        end else if (pointer_in == `FSP_ADDR_CAL) begin
            next_load_data = CAL_BYTE; // RULE22
        end else if (!pointer_in[0] && pointer_in <= `FSP_ADDR_SER_LAST) begin
            unique case (pointer_in[4:1])
                4'h0:    next_load_data = SIG_BYTE0;
                4'h1:    next_load_data = SIG_BYTE1;
                4'h2:    next_load_data = SIG_BYTE2;
                default: next_load_data = SERIAL[8*(pointer_in[4:1]-4'h3) +: 8];
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            load_data_out    <= 8'h00;
            load_special_out <= 1'b0;
        end else begin
            load_special_out <= load_hit && !eep_busy; // RULE17
            if (load_hit && !eep_busy) begin
                load_data_out <= next_load_data;
            end
        end
    end

    // Status read of control register
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            ctrl_rdata_out <= 8'h00;
        end else if (ctrl_rd_in) begin
            ctrl_rdata_out <= {ctrl[7], region_busy_flag, ctrl[5:0]};
        end
    end

    fsp_page_buffer #(
        .WORDS (PAGE_WORDS),
        .AW    (WORD_BITS)
    ) fsp_page_buffer_inst (
        .clk_in      (clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_in       (buf_wr),
        .wr_idx_in   (pointer_in[WORD_BITS:1]),
        .wr_data_in  (data_pair_in),
        .clear_in    (buf_clear),
        .rd_idx_in   (rd_idx),
        .rd_data_out (buf_rdata)
    );
endmodule // fsp_ctrl

// ### design/fsp_defines.svh
// Purpose: Constants for the flash self-programming controller
// Assumes: Included by design files by bare name
// Notes:   Offsets, field positions, reset values and timing counts
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH

// Control register bit positions
`define FSP_BIT_EN        0
`define FSP_BIT_ERASE     1
`define FSP_BIT_WRITE     2
`define FSP_BIT_LOCKSET   3
`define FSP_BIT_REENABLE  4
`define FSP_BIT_SIGNATURE_READ_BIT     5
`define FSP_BIT_BUSY      6
`define FSP_BIT_IRQEN     7

// Low five bit command patterns
`define FSP_CMD_LOAD      5'h01
`define FSP_CMD_ERASE     5'h03
`define FSP_CMD_WRITE     5'h05
`define FSP_CMD_LOCK      5'h09
`define FSP_CMD_REEN      5'h11

// Control register reset value
`define FSP_CTRL_RESET    8'h00

// Arm windows in clock cycles
`define FSP_STORE_WINDOW  3'h4
`define FSP_LOAD_WINDOW   3'h3

// Readback pointer addresses
`define FSP_ADDR_FUSE_LO  16'h0000
`define FSP_ADDR_LOCK     16'h0001
`define FSP_ADDR_FUSE_EXT 16'h0002
`define FSP_ADDR_FUSE_HI  16'h0003
`define FSP_ADDR_CAL      16'h0001
`define FSP_ADDR_SER_LAST 16'h0016

// Flash operation time in microseconds and cycles at 20 MHz
`define FSP_OP_TIME_US    4500
`define FSP_CLK_MHZ       20
`define FSP_OP_CYCLES     (`FSP_OP_TIME_US * `FSP_CLK_MHZ)

`endif

// ### design/fsp_page_buffer.sv
// Purpose: Temporary page buffer of the self-programming controller
// Assumes: Single clock, synchronous active-high reset
// Notes:   Flip-flop storage, random word addressing
`timescale 1ns/1ns
module fsp_page_buffer #(
    parameter int WORDS  = 128,
    parameter int AW     = 7
) (
    // Clock and reset
    input  wire logic          clk_in,
    input  wire logic          sys_rst_in,
    // Write side
    input  wire logic          wr_in,
    input  wire logic [AW-1:0] wr_idx_in,
    input  wire logic [15:0]   wr_data_in,
    input  wire logic          clear_in,
    // Read side
    input  wire logic [AW-1:0] rd_idx_in,
    output logic      [15:0]   rd_data_out
);
    logic [15:0] mem [WORDS];

    genvar i;
    generate
        for (i = 0; i < WORDS; i++) begin : g_word
            always_ff @(posedge clk_in) begin
                if (sys_rst_in || clear_in) begin
                    mem[i] <= 16'hFFFF; // RULE7 RULE9
                end else if (wr_in && wr_idx_in == AW'(i)) begin
                    mem[i] <= wr_data_in; // RULE2 RULE6
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        rd_data_out <= mem[rd_idx_in];
    end
endmodule // fsp_page_buffer

// ### design/fsp_pkg.sv
// Purpose: Types for the flash self-programming controller
// Assumes: Used with fsp_defines.svh
// Notes:   Gray-coded sequencer states
package fsp_pkg;
    typedef enum logic [1:0] {
        FSP_IDLE  = 2'b00,
        FSP_ARMED = 2'b01,
        FSP_BUSY  = 2'b11
    } fsp_state_t;
endpackage

// ### tb/fsp_cpu_model.sv
// Purpose: CPU core model issuing store and load program-memory strobes
// Assumes: Tasks entered at a rising edge right after the control write
// Notes:   Released pointer and data show the inverse of the last value
`timescale 1ns/1ns
module fsp_cpu_model (
    // Clock
    input  wire logic   clk_in,
    // Instruction strobes
    output logic        store_out,
    output logic        load_out,
    output logic [15:0] pointer_out,
    output logic [15:0] data_pair_out
);
    initial begin
        store_out     = 1'b0;
        load_out      = 1'b0;
        pointer_out   = 16'h0000;
        data_pair_out = 16'h0000;
    end
    // Store after gap idle cycles; a gap of four misses the window
    task automatic do_store(input logic [15:0] ptr, input logic [15:0] dat, input int gap);
        repeat (gap) @(posedge clk_in);
        store_out     <= 1'b1;
        pointer_out   <= ptr;
        data_pair_out <= dat;
        @(posedge clk_in);
        store_out     <= 1'b0;
        pointer_out   <= ~ptr;
        data_pair_out <= ~dat;
    endtask
    // Load after gap idle cycles; a gap of three misses the window
    task automatic do_load(input logic [15:0] ptr, input int gap);
        repeat (gap) @(posedge clk_in);
        load_out    <= 1'b1;
        pointer_out <= ptr;
        @(posedge clk_in);
        load_out    <= 1'b0;
        pointer_out <= ~ptr;
    endtask
endmodule // fsp_cpu_model

// ### tb/fsp_ctrl_sva.sv
// Purpose: Port assertions for the self-programming controller
// Assumes: Bound to fsp_ctrl, single clock domain
// Notes:   Erase length counted in helper logic
`timescale 1ns/1ns
module fsp_ctrl_sva #(
    parameter int PAGE_BITS  = 8,
    parameter int NO_READ_WHILE_WRITE_REGION_FIRST = 224,
    parameter int OP_CYCLES  = 20
) (
    // Clock and reset
    input wire logic                 clk_in,
    input wire logic                 sys_rst_in,
    // CPU side
    input wire logic                 store_in,
    input wire logic                 load_in,
    input wire logic [15:0]          pointer_in,
    input wire logic [15:0]          data_pair_in,
    input wire logic [7:0]           load_data_out,
    input wire logic                 load_special_out,
    input wire logic [5:0]           lock_bits_in,
    // Flash side
    input wire logic                 flash_erase_out,
    input wire logic                 flash_write_out,
    input wire logic                 lock_prog_out,
    input wire logic [5:0]           lock_data_out,
    input wire logic [PAGE_BITS-1:0] flash_page_out,
    input wire logic                 rww_block_out,
    input wire logic                 cpu_halt_out,
    input wire logic                 ready_irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (sys_rst_in);
    int unsigned op_len;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !flash_erase_out) begin
            op_len <= 0;
        end else begin
            op_len <= op_len + 1;
        end
    end
    erase_cause_a: assert property ($rose(flash_erase_out) |-> $past(store_in))
        else $error("Erase began without a store");
    write_cause_a: assert property ($rose(flash_write_out) |-> $past(store_in))
        else $error("Write began without a store");
    lock_data_a: assert property ($rose(lock_prog_out) |-> lock_data_out == 6'($past(data_pair_in)))
        else $error("Lock data differs from store data");
    page_latch_a: assert property ($rose(flash_erase_out) |-> flash_page_out == PAGE_BITS'($past(pointer_in) >> 8))
        else $error("Erase page differs from pointer");
    load_answer_a: assert property (load_special_out |-> $past(load_in))
        else $error("Readback without a load");
    lock_value_a: assert property (load_special_out && $past(pointer_in) == 16'h0001 |-> load_data_out[5:0] == $past(lock_bits_in))
        else $error("Lock readback wrong");
    irq_quiet_a: assert property (flash_erase_out && $past(flash_erase_out) |-> !ready_irq_out)
        else $error("Ready interrupt during erase");
    rww_block_a: assert property ($rose(flash_erase_out) && flash_page_out < NO_READ_WHILE_WRITE_REGION_FIRST |-> ##[0:2] rww_block_out)
        else $error("Region not blocked during erase");
    no_read_while_write_region_halt_a: assert property ($rose(flash_erase_out || flash_write_out) && flash_page_out >= NO_READ_WHILE_WRITE_REGION_FIRST |-> ##[0:2] cpu_halt_out)
        else $error("CPU not halted for own region");
    op_len_a: assert property ($fell(flash_erase_out) |-> op_len == OP_CYCLES)
        else $error("Erase length wrong");
    cover property ($rose(flash_write_out));
    cover property (load_special_out);
    cover property ($rose(lock_prog_out));
endmodule // fsp_ctrl_sva

bind fsp_ctrl fsp_ctrl_sva #(
    .PAGE_BITS (PAGE_BITS),
    .NO_READ_WHILE_WRITE_REGION_FIRST(NO_READ_WHILE_WRITE_REGION_FIRST),
    .OP_CYCLES (OP_CYCLES)
) fsp_ctrl_sva_inst (.*);

// ### tb/fsp_ctrl_tb.sv
// Purpose: Self-checking bench for the flash self-programming controller
// Assumes: Shortened flash op time; CPU strobes from the partner model
// Notes:   Fuse and lock cells held at fixed patterns
`timescale 1ns/1ns
module fsp_ctrl_tb;
    localparam int OPC = 300;
    logic        clk_in               = 1'b0;
    logic        sys_rst_in           = 1'b1;
    logic        ctrl_wr_in           = 1'b0;
    logic        ctrl_rd_in           = 1'b0;
    logic [7:0]  ctrl_wdata_in        = 8'h00;
    logic        eeprom_write_busy_in = 1'b0;
    logic [7:0]  ctrl_rdata_out, load_data_out, flash_page_out;
    logic        store_in, load_in, load_special_out, flash_erase_out, flash_write_out;
    logic        lock_prog_out, rww_block_out, cpu_halt_out, ready_irq_out;
    logic [15:0] pointer_in, data_pair_in, flash_wdata_out;
    logic [5:0]  lock_data_out, lk, saw;
    int          err_total   = 0;
    int          comparisons = 0;
    logic [15:0] words [3] = '{16'h1A2B, 16'h3C4D, 16'h5E6F};
    logic [6:0]  idx [3]   = '{7'h05, 7'h02, 7'h00};
    logic [7:0]  bad [4]   = '{8'h07, 8'h0F, 8'h13, 8'h21};
    logic [7:0]  fexp [4]  = '{8'hA6, 8'h2B, 8'h05, 8'h5C};
    logic [7:0]  fmask [4] = '{8'hFF, 8'h3F, 8'h07, 8'hFF};

    always #25 clk_in = ~clk_in;

    fsp_cpu_model fsp_cpu_model_inst (
        .clk_in       (clk_in),
        .store_out    (store_in),
        .load_out     (load_in),
        .pointer_out  (pointer_in),
        .data_pair_out(data_pair_in)
    );
    fsp_ctrl #(.OP_CYCLES(OPC)) fsp_ctrl_inst (
        .fuse_low_byte_in     (8'hA6),
        .fuse_high_byte_in    (8'h5C),
        .fuse_extended_byte_in(3'h5),
        .lock_bits_in         (6'h2B),
        .*
    );

    task automatic tally_and_finish;
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic ctrl_write(input logic [7:0] val);
        @(posedge clk_in);
        ctrl_wr_in    <= 1'b1;
        ctrl_wdata_in <= val;
        @(posedge clk_in);
        ctrl_wr_in    <= 1'b0;
    endtask
    task automatic ctrl_read(output logic [7:0] val);
        @(posedge clk_in);
        ctrl_rd_in <= 1'b1;
        @(posedge clk_in);
        ctrl_rd_in <= 1'b0;
        #1 val = ctrl_rdata_out;
    endtask
    // Flags: op, region block, halt, then one per loaded word seen
    task automatic run_op(input logic [7:0] cmd, input logic [15:0] ptr,
                          input logic [15:0] dat, input int gap);
        int   n;
        logic busy;
        saw = 6'h00;
        ctrl_write(cmd);
        fsp_cpu_model_inst.do_store(ptr, dat, gap);
        for (n = 0; n < 1000; n++) begin
            @(posedge clk_in);
            #1;
            busy = flash_erase_out | flash_write_out | lock_prog_out;
            saw[0] |= busy;
            saw[1] |= rww_block_out;
            saw[2] |= cpu_halt_out;
            for (int k = 0; k < 3; k++) begin
                saw[3+k] |= flash_write_out && flash_wdata_out === words[k];
            end
            if (lock_prog_out) begin
                lk = lock_data_out;
            end
            if (!busy && (saw[0] || n == 8)) begin
                break;
            end
        end
        if (n == 1000) begin
            err_total++;
            tally_and_finish;
        end
    endtask
    task automatic load_words;
        for (int k = 0; k < 3; k++) begin
            ctrl_write(8'h01);
            fsp_cpu_model_inst.do_store({8'h03, idx[k], 1'b0}, words[k], k);
        end
    endtask
    task automatic lock_read(input logic [15:0] ptr, input int gap, output logic [8:0] got);
        ctrl_write(8'h09);
        fsp_cpu_model_inst.do_load(ptr, gap);
        #1 got = {load_special_out, load_data_out};
    endtask

    initial begin
        logic [7:0] r;
        logic [8:0] got;
        repeat (20) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        ctrl_read(r);
        check(16'(r), 16'h0000);
        check(flash_wdata_out, 16'hFFFF);
        foreach (bad[i]) begin
            run_op(bad[i], 16'h0300, 16'h0000, 0);
            check(16'(saw), 16'h0000);
        end
        load_words();
        run_op(8'h03, 16'h0300, 16'hFFFF, 3);
        check(16'(saw), 16'h0003);
        ctrl_read(r);
        check(16'(r & 8'h41), 16'h0040);
        run_op(8'h05, 16'h0300, 16'hFFFF, 2);
        check(16'(saw), 16'h003B);
        run_op(8'h11, 16'h0000, 16'h0000, 0);
        ctrl_read(r);
        check(16'(r & 8'h40), 16'h0000);
        run_op(8'h05, 16'h0300, 16'h0000, 0);
        check(16'(saw), 16'h0003);
        run_op(8'h11, 16'h0000, 16'h0000, 0);
        load_words();
        run_op(8'h11, 16'h0000, 16'h0000, 0);
        run_op(8'h05, 16'h0300, 16'h0000, 0);
        check(16'(saw), 16'h0003);
        run_op(8'h11, 16'h0000, 16'h0000, 0);
        load_words();
        eeprom_write_busy_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        run_op(8'h03, 16'h0300, 16'h0000, 0);
        check(16'(saw), 16'h0000);
        lock_read(16'h0001, 0, got);
        check(16'(got[8]), 16'h0000);
        eeprom_write_busy_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        run_op(8'h05, 16'h0300, 16'h0000, 0);
        check(16'(saw), 16'h0003);
        run_op(8'h11, 16'h0000, 16'h0000, 0);
        run_op(8'h03, 16'h0300, 16'h0000, 4);
        check(16'(saw), 16'h0000);
        run_op(8'h03, 16'hE600, 16'h0000, 1);
        check(16'(saw), 16'h0007);
        run_op(8'h05, 16'hF000, 16'h0000, 0);
        check(16'(saw), 16'h0007);
        run_op(8'h11, 16'h0000, 16'h0000, 0);
        run_op(8'h09, 16'h0001, 16'h00C5, 0);
        check({saw, 4'h0, lk}, {6'h01, 4'h0, 6'h05});
        for (int a = 0; a < 4; a++) begin
            lock_read(16'(a), a % 3, got);
            check(16'(got & {1'b1, fmask[a]}), 16'(9'h100 | fexp[a]));
        end
        ctrl_read(r);
        check(16'(r & 8'h09), 16'h0000);
        lock_read(16'h0001, 3, got);
        check(16'(got[8]), 16'h0000);
        ctrl_write(8'h21);
        fsp_cpu_model_inst.do_load(16'h0004, 2);
        #1 check(16'({load_special_out, load_data_out}), 16'h013C);
        run_op(8'h83, 16'h0400, 16'h0000, 0);
        @(posedge clk_in);
        #1 check(16'(ready_irq_out), 16'h0001);
        run_op(8'h11, 16'h0000, 16'h0000, 0);
        check(16'(ready_irq_out), 16'h0000);
        tally_and_finish;
    end
endmodule // fsp_ctrl_tb
